// >>> eocs_osc_model.sv
/*
  Far-side model: external clock source on the oscillator pin and the
  crystal amplitude detector.
  Assumes the design's pin-claim outputs tell which pins it has taken.
*/
`default_nettype none
module eocs_osc_model #(
  parameter int HALF = 8,
  parameter int AMP_DLY = 2000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic xtal_claim,
  input wire logic pin_claim,
  input wire logic pins_low,
  output logic osc_pin,
  output logic amp_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  int ph;
  int amp;
  logic lvl;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph <= 0;
      lvl <= 1'b0;
      amp <= 0;
    end else begin
      ph <= (ph == HALF - 1) ? 0 : ph + 1;
      if (ph == HALF - 1) begin
        lvl <= ~lvl;
      end
      amp <= (xtal_claim && pins_low) ? ((amp < AMP_DLY) ? amp + 1 : amp) : 0;
    end
  end
  // Released pin wiggles every cycle while pins_low is clear, and is held at 0 while it is set
  assign osc_pin = pin_claim ? lvl : (pins_low ? 1'b0 : ph[0]);
  // Amplitude good only after a stretch of crystal drive
  assign amp_ok = xtal_claim && (amp >= AMP_DLY);
endmodule // eocs_osc_model
`default_nettype wire

// >>> eocs_pkg.sv
/*
  Package for the external oscillator clock select block: register map,
  field positions, reset values, mode codes, timing counts and carriers.
  Assumes a 50 MHz system clock and an AXI4-Lite register bus.
*/
`default_nettype none
package eocs_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] EOCS_EXT_OSC_CTRL_IDX = 8'hb1;
  localparam logic [11:0] EOCS_ADDR_EXT_OSC_CTRL = {2'h0, EOCS_EXT_OSC_CTRL_IDX, 2'h0};
  localparam logic [11:0] EOCS_ADDR_CLK_SEL = 12'h400;
  localparam logic [11:0] EOCS_ADDR_IRQ_STAT = 12'h404;
  localparam logic [11:0] EOCS_ADDR_IRQ_MASK = 12'h408;
  localparam logic [11:0] EOCS_ADDR_STATUS = 12'h40c;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int EOCS_VALID_BIT = 7;
  localparam int EOCS_MODE_LSB = 4;
  localparam int EOCS_MODE_MSB = 6;
  localparam int EOCS_FREQ_LSB = 0;
  localparam int EOCS_FREQ_MSB = 2;
  localparam int EOCS_IRQ_VALID_RISE = 0;
  localparam int EOCS_IRQ_VALID_FALL = 1;
  localparam int EOCS_IRQ_SRC_SWITCH = 2;
  localparam int EOCS_IRQ_W = 3;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [2:0] EOCS_MODE_RST = 3'h0;
  localparam logic [2:0] EOCS_FREQ_RST = 3'h0;
  localparam logic EOCS_SRC_RST = 1'b0;
  localparam logic [EOCS_IRQ_W-1:0] EOCS_IRQ_RST = 3'h0;
  // ----------------------------------------
  // Mode codes
  // ----------------------------------------
  localparam logic [2:0] EOCS_MODE_CMOS = 3'h2;
  localparam logic [2:0] EOCS_MODE_CMOS_DIV2 = 3'h3;
  localparam logic [2:0] EOCS_MODE_RC = 3'h4;
  localparam logic [2:0] EOCS_MODE_CAP = 3'h5;
  localparam logic [2:0] EOCS_MODE_XTAL = 3'h6;
  localparam logic [2:0] EOCS_MODE_XTAL_DIV2 = 3'h7;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int EOCS_CLK_HZ = 50000000;
  localparam int EOCS_XTAL_SETTLE_US = 1000;
  localparam int EOCS_XTAL_SETTLE_CYC = (EOCS_CLK_HZ / 1000000) * EOCS_XTAL_SETTLE_US;
  localparam int EOCS_CNT_W = 16;
  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] mode;
    logic [2:0] freq;
    logic src_ext;
  } eocs_ctrl_t;
  typedef enum logic [2:0] {
    EOCS_XT_OFF = 3'b001,
    EOCS_XT_SETTLE = 3'b010,
    EOCS_XT_VALID = 3'b100
  } eocs_xt_t;
  typedef struct packed {
    eocs_ctrl_t ctrl;
    eocs_xt_t xt;
    logic [EOCS_CNT_W-1:0] cnt;
    logic [EOCS_IRQ_W-1:0] stat;
    logic [EOCS_IRQ_W-1:0] mask;
    logic irq;
    logic ext_div;
    logic ext_clk_out;
    logic sys_clk_out;
    logic [2:0] pin_sync;
    logic pin_level;
    logic xtal_pins_claim;
    logic p03_claim;
    logic awv;
    logic [11:0] awa;
    logic wv;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } eocs_state_t;
endpackage : eocs_pkg
`default_nettype wire

// >>> eocs_top.sv
/*
  External oscillator control, crystal valid tracking and system clock
  source select, reached over AXI4-Lite.
  Assumes the oscillator clock pin and the crystal amplitude-good level
  arrive asynchronously; the internal oscillator is a synchronous input.
*/
// The AXI4-Lite interface to the registers is this design's own decision.
// Notes on behaviour
// - Valid flag sits in control bit 7, read only, meaningful in crystal modes.
// - Mode field bits 6..4: 00x off, 010 CMOS, 100 RC, 101 cap, 110 crystal.
// - Modes 011 and 111 halve the external clock; 010, 100, 101 and 110 pass it undivided.
// - System clock comes from external oscillator only when select bit 0 is 1.
// - External clock stays available to timers while internal drives the system.
// - Source may change on the fly once the new oscillator is enabled and settled.
// - Internal source may be selected in the write right after enabling it.
// - Hardware alone sets the valid flag once the crystal has settled.
// - RC and capacitor modes are usable at once, with no settling interval.
// - Crystal mode claims port 0 pins 2 and 3; CMOS, RC and capacitor modes claim only pin 3.
`default_nettype none
module eocs_top
  import eocs_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic EXT_OSC_PIN,
  input wire logic XTAL_AMP_OK,
  input wire logic INT_OSC_CLK,
  output logic EXT_OSC_CLK,
  output logic SYS_CLK_OUT,
  output logic XTAL_PINS_CLAIM,
  output logic P03_CLAIM,
  output logic IRQ,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  localparam logic [EOCS_CNT_W-1:0] SETTLE_CNT = EOCS_CNT_W'(EOCS_XTAL_SETTLE_CYC);

  eocs_state_t s_q, s_d;
  logic [2:0] amp_sync_q;
  logic amp_ok;
  logic amp_lvl_q;
  logic xtal_mode, div_mode, valid_flag, wr_go;
  logic [7:0] ctrl_rd;

  // ----------------------------------------
  // Asynchronous amplitude detector input
  // ----------------------------------------
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      amp_sync_q <= 3'h0;
      amp_lvl_q <= 1'b0;
    end else if (CE) begin
      amp_sync_q <= {amp_sync_q[1:0], XTAL_AMP_OK};
      if (amp_sync_q[1] == amp_sync_q[2]) begin
        amp_lvl_q <= amp_sync_q[2];
      end
    end
  end
  assign amp_ok = amp_lvl_q;

  assign xtal_mode = s_q.ctrl.mode[2:1] == 2'b11;
  assign div_mode = s_q.ctrl.mode[1:0] == 2'b11 && s_q.ctrl.mode != EOCS_MODE_RST;
  assign valid_flag = xtal_mode && s_q.xt == EOCS_XT_VALID;
  assign ctrl_rd = {valid_flag, s_q.ctrl.mode, 1'b0, s_q.ctrl.freq};
  assign wr_go = s_q.awv && s_q.wv && !s_q.bvalid;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [EOCS_IRQ_W-1:0] ev;
    logic valid_now;
    logic [7:0] wb;
    ev = '0;
    valid_now = 1'b0;
    wb = '0;
    s_d = s_q;
    // Crystal settling tracker
    unique case (s_q.xt)
      EOCS_XT_OFF: begin
        s_d.cnt = '0;
        if (xtal_mode) begin
          s_d.xt = EOCS_XT_SETTLE;
        end
      end
      EOCS_XT_SETTLE: begin
        if (!xtal_mode) begin
          s_d.xt = EOCS_XT_OFF;
        end else if (s_q.cnt >= SETTLE_CNT - 1'b1 && amp_ok) begin
          s_d.xt = EOCS_XT_VALID;
        end else if (s_q.cnt < SETTLE_CNT - 1'b1) begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      EOCS_XT_VALID: begin
        if (!xtal_mode || !amp_ok) begin
          s_d.xt = EOCS_XT_OFF;
        end
      end
    endcase
    valid_now = s_d.xt == EOCS_XT_VALID;
    ev[EOCS_IRQ_VALID_RISE] = valid_now && s_q.xt != EOCS_XT_VALID;
    ev[EOCS_IRQ_VALID_FALL] = !valid_now && s_q.xt == EOCS_XT_VALID;
    // External clock path, running for timers in every mode except off (00x)
    s_d.pin_sync = {s_q.pin_sync[1:0], EXT_OSC_PIN};
    if (s_q.pin_sync[1] == s_q.pin_sync[2]) begin
      s_d.pin_level = s_q.pin_sync[2];
    end
    if (s_q.ctrl.mode[2:1] == 2'b00) begin
      s_d.ext_div = 1'b0;
      s_d.ext_clk_out = 1'b0;
    end else if (div_mode) begin
      if (s_d.pin_level && !s_q.pin_level) begin
        s_d.ext_div = !s_q.ext_div;
      end
      s_d.ext_clk_out = s_d.ext_div;
    end else begin
      s_d.ext_clk_out = s_d.pin_level;
    end
    s_d.sys_clk_out = s_q.ctrl.src_ext ? s_d.ext_clk_out : INT_OSC_CLK;
    s_d.xtal_pins_claim = xtal_mode;
    s_d.p03_claim = s_q.ctrl.mode[2:1] != 2'b00;
    // Register bus
    if (S_AXI_AWVALID && !s_q.awv) begin
      s_d.awv = 1'b1;
      s_d.awa = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !s_q.wv) begin
      s_d.wv = 1'b1;
      s_d.wd = S_AXI_WDATA;
      s_d.ws = S_AXI_WSTRB;
    end
    if (wr_go) begin
      s_d.awv = 1'b0;
      s_d.wv = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = 2'b00;
      wb = s_q.wd[7:0];
      unique case ({s_q.ws[0], s_q.awa[11:2], 2'b00})
        {1'b1, EOCS_ADDR_EXT_OSC_CTRL}: begin
          s_d.ctrl.mode = wb[EOCS_MODE_MSB:EOCS_MODE_LSB];
          s_d.ctrl.freq = wb[EOCS_FREQ_MSB:EOCS_FREQ_LSB];
        end
        {1'b1, EOCS_ADDR_CLK_SEL}: begin
          s_d.ctrl.src_ext = wb[0];
          ev[EOCS_IRQ_SRC_SWITCH] = wb[0] != s_q.ctrl.src_ext;
        end
        {1'b1, EOCS_ADDR_IRQ_MASK}: begin
          s_d.mask = wb[EOCS_IRQ_W-1:0];
        end
        {1'b1, EOCS_ADDR_IRQ_STAT}: begin
          s_d.stat = s_q.stat & ~wb[EOCS_IRQ_W-1:0];
        end
        {1'b0, EOCS_ADDR_EXT_OSC_CTRL}, {1'b0, EOCS_ADDR_CLK_SEL},
        {1'b0, EOCS_ADDR_IRQ_MASK}, {1'b0, EOCS_ADDR_IRQ_STAT},
        {1'b0, EOCS_ADDR_STATUS}, {1'b1, EOCS_ADDR_STATUS}: begin
        end
        default: begin
          s_d.bresp = 2'b10;
        end
      endcase
    end
    if (s_q.bvalid && S_AXI_BREADY) begin
      s_d.bvalid = 1'b0;
    end
    // Set wins over clear
    s_d.stat = s_d.stat | ev;
    s_d.irq = |(s_d.stat & s_d.mask);
    if (S_AXI_ARVALID && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = 2'b00;
      s_d.rdata = '0;
      unique case ({S_AXI_ARADDR[11:2], 2'b00})
        EOCS_ADDR_EXT_OSC_CTRL: s_d.rdata[7:0] = ctrl_rd;
        EOCS_ADDR_CLK_SEL: s_d.rdata[0] = s_q.ctrl.src_ext;
        EOCS_ADDR_IRQ_STAT: s_d.rdata[EOCS_IRQ_W-1:0] = s_q.stat;
        EOCS_ADDR_IRQ_MASK: s_d.rdata[EOCS_IRQ_W-1:0] = s_q.mask;
        EOCS_ADDR_STATUS: s_d.rdata[2:0] = {s_q.p03_claim, s_q.xtal_pins_claim, s_q.ext_clk_out};
        default: s_d.rresp = 2'b10;
      endcase
    end else if (s_q.rvalid && S_AXI_RREADY) begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= '0;
      s_q.ctrl.mode <= EOCS_MODE_RST;
      s_q.ctrl.freq <= EOCS_FREQ_RST;
      s_q.ctrl.src_ext <= EOCS_SRC_RST;
      s_q.xt <= EOCS_XT_OFF;
      s_q.stat <= EOCS_IRQ_RST;
      s_q.mask <= EOCS_IRQ_RST;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign EXT_OSC_CLK = s_q.ext_clk_out;
  assign SYS_CLK_OUT = s_q.sys_clk_out;
  assign XTAL_PINS_CLAIM = s_q.xtal_pins_claim;
  assign P03_CLAIM = s_q.p03_claim;
  assign IRQ = s_q.irq;
  assign S_AXI_AWREADY = !s_q.awv;
  assign S_AXI_WREADY = !s_q.wv;
  assign S_AXI_BVALID = s_q.bvalid;
  assign S_AXI_BRESP = s_q.bresp;
  assign S_AXI_ARREADY = !s_q.rvalid;
  assign S_AXI_RVALID = s_q.rvalid;
  assign S_AXI_RRESP = s_q.rresp;
  assign S_AXI_RDATA = s_q.rdata;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  sequence s_xtal_enter;
    CE && s_q.xt == EOCS_XT_OFF && xtal_mode;
  endsequence
  sequence s_settling;
    !valid_flag [*8];
  endsequence

  property p_valid_only_xtal;
    !xtal_mode |-> !ctrl_rd[7];
  endproperty
  a_valid_only_xtal: assert property (p_valid_only_xtal) else $error("valid set outside crystal mode");

  property p_bit3_zero;
    ctrl_rd[3] == 1'b0;
  endproperty
  a_bit3_zero: assert property (p_bit3_zero) else $error("control bit 3 not zero");

  property p_no_early_valid;
    s_xtal_enter |=> s_settling;
  endproperty
  a_no_early_valid: assert property (p_no_early_valid) else $error("valid rose before settling");

  property p_valid_needs_count;
    $rose(s_q.xt == EOCS_XT_VALID) |-> $past(s_q.cnt) >= SETTLE_CNT - 1'b1;
  endproperty
  a_valid_needs_count: assert property (p_valid_needs_count) else $error("valid without settle time");

  property p_claim_pins;
    CE |=> XTAL_PINS_CLAIM == $past(xtal_mode) && P03_CLAIM == ($past(s_q.ctrl.mode[2:1]) != 2'b00);
  endproperty
  a_claim_pins: assert property (p_claim_pins) else $error("pin claim mismatch");

  property p_sys_int;
    RST_N && CE && !s_q.ctrl.src_ext |=> SYS_CLK_OUT == $past(INT_OSC_CLK);
  endproperty
  a_sys_int: assert property (p_sys_int) else $error("internal source not selected");

  property p_div_toggle;
    CE && div_mode && s_q.pin_level == s_q.pin_sync[2] && s_q.pin_sync[1] == s_q.pin_sync[2]
      |=> $stable(s_q.ext_div);
  endproperty
  a_div_toggle: assert property (p_div_toggle) else $error("divider toggled without edge");

  property p_undiv;
    CE && s_q.ctrl.mode[2:1] != 2'b00 && !div_mode |=> EXT_OSC_CLK == s_q.pin_level;
  endproperty
  a_undiv: assert property (p_undiv) else $error("undivided clock mismatch");

  property p_mode_write;
    CE && wr_go && s_q.ws[0] && {s_q.awa[11:2], 2'b00} == EOCS_ADDR_EXT_OSC_CTRL
      |=> s_q.ctrl.mode == $past(s_q.wd[6:4]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode field not written");

  property p_irq_level;
    IRQ == |(s_q.stat & s_q.mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq mismatch");

  property p_sys_ext;
    RST_N && CE && s_q.ctrl.src_ext |=> SYS_CLK_OUT == EXT_OSC_CLK;
  endproperty
  a_sys_ext: assert property (p_sys_ext) else $error("external source not selected");

  property p_off_quiet;
    RST_N && CE && s_q.ctrl.mode[2:1] == 2'b00 |=> !EXT_OSC_CLK;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("clock runs while circuit off");

  property p_valid_drop;
    CE && s_q.xt == EOCS_XT_VALID && (!amp_ok || !xtal_mode) |=> !valid_flag;
  endproperty
  a_valid_drop: assert property (p_valid_drop) else $error("valid kept after loss");

  property p_bresp_hold;
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");

  property p_rdata_hold;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data dropped");

  sequence s_aw_w_taken;
    CE && S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY && !S_AXI_BVALID;
  endsequence
  property p_write_walk;
    s_aw_w_taken ##1 CE |=> S_AXI_BVALID;
  endproperty
  a_write_walk: assert property (p_write_walk) else $error("write response late");

  sequence s_ar_taken;
    CE && S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  property p_read_walk;
    s_ar_taken |=> S_AXI_RVALID && !S_AXI_ARREADY;
  endproperty
  a_read_walk: assert property (p_read_walk) else $error("read data late");
endmodule // eocs_top
`default_nettype wire

// >>> external_oscillator_clock_select_tb.sv
/*
  Self-checking bench for the oscillator control block over AXI4-Lite.
  Assumes the far-side model in eocs_osc_model and a 50 MHz clock.
*/
`default_nettype none
module external_oscillator_clock_select_tb
  import eocs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, int_clk, awv, wv, arv, bre, rre;
  logic awr, wr, arr, bv, rv, ext, sys, xcl, pcl, irq, pin, amp, ce, plow;
  logic [3:0] wstb;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd, rdd;
  logic [1:0] bsp, rsp, resp_w, resp_r;
  logic [2:0] f;
  int errors, compares, ic, ee, es, ei, m;
  eocs_top eocs_top_inst (.CLK_SYS(clk), .RST_N(rst_n), .CE(ce), .EXT_OSC_PIN(pin),
    .XTAL_AMP_OK(amp), .INT_OSC_CLK(int_clk), .EXT_OSC_CLK(ext), .SYS_CLK_OUT(sys),
    .XTAL_PINS_CLAIM(xcl), .P03_CLAIM(pcl), .IRQ(irq), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(wstb),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(bsp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdd), .S_AXI_RRESP(rsp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre));
  eocs_osc_model eocs_osc_model_inst (.clk(clk), .rst_n(rst_n), .xtal_claim(xcl),
    .pin_claim(pcl), .pins_low(plow), .osc_pin(pin), .amp_ok(amp));
  // ----------------------------------------
  // Clocks and helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    ic <= (ic == 2) ? 0 : ic + 1;
    if (ic == 2) begin
      int_clk <= ~int_clk;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (!bv && n < 200);
    resp_w = bsp;
    bre <= 1'b0;
    if (n >= 200) chk(32'h0, 32'h1);
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [11:0] a);
    int n;
    n = 0;
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arv && arr) arv <= 1'b0;
    end while (!rv && n < 200);
    rd = rdd;
    resp_r = rsp;
    rre <= 1'b0;
    if (n >= 200) chk(32'h0, 32'h1);
    @(posedge clk);
  endtask
  // Count level changes of both clock outputs and the internal clock
  task automatic count(input int n);
    logic pe, ps, pi;
    repeat (8) @(posedge clk);
    ee = 0;
    es = 0;
    ei = 0;
    pe = ext;
    ps = sys;
    pi = int_clk;
    repeat (n) begin
      @(posedge clk);
      ee += int'(ext !== pe);
      es += int'(sys !== ps);
      ei += int'(int_clk !== pi);
      pe = ext;
      ps = sys;
      pi = int_clk;
    end
  endtask
  function automatic logic near(input int a, input int b);
    return (a - b <= 1) && (b - a <= 1);
  endfunction
  task automatic conclude();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (70000) @(posedge clk);
    errors++;
    conclude();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {rst_n, int_clk, awv, wv, arv, bre, rre, awa, ara, wd, ic, errors, compares} = '0;
    ce = 1'b1;
    wstb = 4'h1;
    plow = 1'b0;
    void'($urandom(32'h5191f4e1));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(EOCS_ADDR_EXT_OSC_CTRL);
    chk(rd, 32'h0);
    rd_reg(EOCS_ADDR_CLK_SEL);
    chk(rd, 32'h0);
    rd_reg(12'h100);
    chk(resp_r, 2'b10);
    wr_reg(12'h100, 32'hff);
    chk(resp_w, 2'b10);
    $display("test reset and unmapped done");
    for (m = 0; m < 8; m++) begin
      f = 3'($urandom);
      if (m == 6) plow <= 1'b1;
      wr_reg(EOCS_ADDR_EXT_OSC_CTRL, {24'h0, 1'b1, m[2:0], 1'b1, f});
      rd_reg(EOCS_ADDR_EXT_OSC_CTRL);
      chk(rd, {24'h0, 1'b0, m[2:0], 1'b0, f});
      chk(pcl, m > 1);
      chk(xcl, m > 5);
      rd_reg(EOCS_ADDR_STATUS);
      chk(rd[2:1], {m > 1, m > 5});
      count(320);
      chk(near(ee, (m < 2) ? 0 : (m == 3 || m == 7) ? 20 : 40), 1'b1);
      chk(near(es, ei), 1'b1);
    end
    $display("test mode sweep done");
    ce <= 1'b0;
    count(40);
    chk(ee + es, 32'h0);
    ce <= 1'b1;
    $display("test clock enable done");
    wr_reg(EOCS_ADDR_EXT_OSC_CTRL, 32'h67);
    rd_reg(EOCS_ADDR_EXT_OSC_CTRL);
    chk(rd[7], 1'b0);
    repeat (EOCS_XTAL_SETTLE_CYC) @(posedge clk);
    m = 0;
    do begin
      rd_reg(EOCS_ADDR_EXT_OSC_CTRL);
      m++;
    end while (rd[7] !== 1'b1 && m < 100);
    chk(rd, 32'he7);
    wstb <= 4'h0;
    wr_reg(EOCS_ADDR_EXT_OSC_CTRL, 32'h0);
    wstb <= 4'h1;
    chk(resp_w, 2'b00);
    rd_reg(EOCS_ADDR_EXT_OSC_CTRL);
    chk(rd, 32'he7);
    rd_reg(EOCS_ADDR_IRQ_STAT);
    chk(rd, 32'h1);
    chk(irq, 1'b0);
    wr_reg(EOCS_ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    wr_reg(EOCS_ADDR_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    wr_reg(EOCS_ADDR_EXT_OSC_CTRL, 32'h60);
    rd_reg(EOCS_ADDR_EXT_OSC_CTRL);
    chk(rd, 32'he0);
    wr_reg(EOCS_ADDR_IRQ_MASK, 32'h4);
    $display("test crystal bring-up done");
    wr_reg(EOCS_ADDR_CLK_SEL, 32'h1);
    count(320);
    chk(near(es, ee) && near(ee, 40), 1'b1);
    chk(irq, 1'b1);
    wr_reg(EOCS_ADDR_CLK_SEL, 32'h0);
    count(320);
    chk(near(es, ei) && near(ee, 40), 1'b1);
    wr_reg(EOCS_ADDR_EXT_OSC_CTRL, 32'h0);
    rd_reg(EOCS_ADDR_EXT_OSC_CTRL);
    chk(rd, 32'h0);
    rd_reg(EOCS_ADDR_IRQ_STAT);
    chk(rd, 32'h6);
    $display("test clock switch done");
    conclude();
  end
endmodule // external_oscillator_clock_select_tb
`default_nettype wire
